/* File: inc/packet_format_pkg.sv */
// Purpose: shared constants for the packet format configuration block
// Assumes: register index times four gives the apb byte address
// Notes: reset values of the configuration registers are plain zeros
package packet_format_pkg;
    // ----------------------------------------------------------------
    // register indices
    // ----------------------------------------------------------------
    localparam int PADDR_W = 12;
    localparam logic [9:0] IDX_SYNC_MID = 10'h122;
    localparam logic [9:0] IDX_SYNC_LOW = 10'h123;
    localparam logic [9:0] IDX_TX_PTR = 10'h124;
    localparam logic [9:0] IDX_RX_PTR = 10'h125;
    localparam logic [9:0] IDX_FRAME = 10'h126;
    localparam logic [9:0] IDX_LIMIT = 10'h130;
    localparam logic [9:0] IDX_IRQ_STAT = 10'h131;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h132;
    localparam logic [9:0] IDX_STATUS = 10'h133;
    // ----------------------------------------------------------------
    // fields and reset values
    // ----------------------------------------------------------------
    localparam int BIT_MSB_FIRST = 7;
    localparam int BIT_FIXED = 6;
    localparam int BIT_CRC_EN = 5;
    localparam int MODE_HI = 4;
    localparam int MODE_LO = 3;
    localparam int OFFSET_HI = 2;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [5:0] RST_IRQ = 6'h00;
    localparam logic [9:0] LEN_BIAS = 10'h004;
    localparam logic [3:0] WORD_LAST = 4'hf;
    localparam logic [2:0] BYTE_LAST = 3'h7;
    // ----------------------------------------------------------------
    // interrupt status bits
    // ----------------------------------------------------------------
    localparam int IRQ_W = 6;
    localparam int IRQ_TX_DONE = 0;
    localparam int IRQ_RX_DONE = 1;
    localparam int IRQ_CRC_ERR = 2;
    localparam int IRQ_LEN_ERR = 3;
    localparam int IRQ_PREAMBLE = 4;
    localparam int IRQ_SYNC = 5;
    // ----------------------------------------------------------------
    // data path select codes
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_PACKET = 2'h0,
        MODE_SPORT_PRE = 2'h1,
        MODE_SPORT_SYNC = 2'h2,
        MODE_UNUSED = 2'h3
    } data_path_t;
endpackage : packet_format_pkg

/* File: rtl/frame_crc.sv */
// Purpose: bit serial crc register, msb first, no output inversion
// Assumes: clear and shift are never high together
// Notes: message followed by its crc leaves a zero residue
`timescale 1ns/1ns
module frame_crc #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] POLY = 16'h1021,
    parameter logic [WIDTH-1:0] INIT = 16'hffff
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic shift,
    input wire logic din,
    output logic [WIDTH-1:0] crc
);
    initial
    begin
        if (WIDTH < 2) $error("crc width too small");
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            crc <= INIT;
        else if (clear)
            crc <= INIT;
        else if (shift)
            crc <= {crc[WIDTH-2:0], 1'b0} ^ ((crc[WIDTH-1] ^ din) ? POLY : '0);
    end
endmodule : frame_crc

/* File: rtl/packet_format_config.sv */
// Purpose: packet handler configuration registers and framing datapath
// Assumes: apb master; packet ram answers one cycle after its read cycle
// Notes: tx and rx share the ram port and never run together
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
module packet_format_config
    import packet_format_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [packet_format_pkg::PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic tx_start,
    input wire logic tx_bit_req,
    output logic tx_bit,
    output logic tx_bit_valid,
    input wire logic rx_bit_pin,
    input wire logic rx_tick_pin,
    input wire logic preamble_det,
    input wire logic sync_det,
    output logic [15:0] sync_pattern,
    output logic [7:0] ram_addr,
    output logic ram_rd_en,
    input wire logic [7:0] ram_rdata,
    output logic ram_wr_en,
    output logic [7:0] ram_wdata,
    output logic general_irq_output,
    output logic sport_rx_en,
    output logic sport_data,
    output logic irq
);
    import packet_format_pkg::*;

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_TX_SYNC, ST_TX_WAIT, ST_TX_TAKE, ST_TX_DATA,
        ST_TX_CRC, ST_RX_DATA, ST_RX_CRC, ST_RX_CHECK
    } state_t;

    state_t state_r;
    logic [7:0] sync_mid_r, sync_low_r, tx_ptr_r, rx_ptr_r, frame_r, limit_r;
    logic [IRQ_W-1:0] stat_r, mask_r, ev_r, ev_set, w1c;
    logic [8:0] idx_r, plen_r, plen_calc;
    logic [3:0] cnt_r;
    logic [7:0] byte_r, first_byte, rx_byte_nxt;
    logic [1:0] pin_s1, pin_s2, pin_s3, pin_q;
    logic tick_prev_r, rx_tick, rx_bit_q;
    logic msb_first, fixed_len, crc_en, pkt_mode, len_bad, exp_bit;
    logic crc_clr, crc_shift, crc_din, last_byte;
    logic [15:0] crc_val;
    data_path_t mode;
    logic setup, access_done, known;
    logic [9:0] reg_idx;
    logic [31:0] rd_val;

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic bit_pick(input logic [7:0] b, input logic [2:0] n,
                                      input logic msb);
        bit_pick = msb ? b[BYTE_LAST - n] : b[n];
    endfunction : bit_pick

    function automatic logic [8:0] pay_len(input logic [7:0] len, input logic [2:0] off);
        logic [9:0] s;
        s = {2'h0, len} + {7'h00, off};
        pay_len = (s < LEN_BIAS) ? 9'h000 : 9'(s - LEN_BIAS);
    endfunction : pay_len

    function automatic logic idx_known(input logic [9:0] i);
        idx_known = (i >= IDX_SYNC_MID && i <= IDX_FRAME) ||
                    (i >= IDX_LIMIT && i <= IDX_STATUS);
    endfunction : idx_known

    // ----------------------------------------------------------------
    // configuration decode
    // ----------------------------------------------------------------
    assign msb_first = frame_r[BIT_MSB_FIRST];
    assign fixed_len = frame_r[BIT_FIXED];
    assign crc_en = frame_r[BIT_CRC_EN];
    assign mode = data_path_t'(frame_r[MODE_HI:MODE_LO]);
    assign pkt_mode = (mode == MODE_PACKET);
    assign sync_pattern = {sync_mid_r, sync_low_r};

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin_s1 <= 2'h0;
            pin_s2 <= 2'h0;
            pin_s3 <= 2'h0;
        end
        else
        begin
            pin_s1 <= {rx_tick_pin, rx_bit_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    for (genvar g = 0; g < 2; g++)
    begin : g_pin
        always_ff @(posedge core_clk or negedge rst_b)
        begin
            if (!rst_b)
                pin_q[g] <= 1'b0;
            else if (pin_s2[g] == pin_s3[g])
                pin_q[g] <= pin_s3[g];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            tick_prev_r <= 1'b0;
        else
            tick_prev_r <= pin_q[1];
    end

    assign rx_tick = pin_q[1] & ~tick_prev_r;
    assign rx_bit_q = pin_q[0];

    // ----------------------------------------------------------------
    // length and crc control
    // ----------------------------------------------------------------
    assign rx_byte_nxt = msb_first ? {byte_r[6:0], rx_bit_q} : {rx_bit_q, byte_r[7:1]};
    assign first_byte = (state_r == ST_TX_TAKE) ? ram_rdata : rx_byte_nxt;
    assign plen_calc = pay_len(fixed_len ? limit_r : first_byte, frame_r[OFFSET_HI:0]);
    assign len_bad = (plen_calc == 9'h000) || (!fixed_len && first_byte > limit_r);
    assign last_byte = (idx_r + 9'h001) == ((idx_r == 9'h000) ? plen_calc : plen_r);
    assign exp_bit = bit_pick(byte_r, cnt_r[2:0], msb_first);
    assign crc_clr = (state_r == ST_IDLE);
    assign crc_shift = ((state_r == ST_TX_DATA) && tx_bit_req) ||
                       ((state_r == ST_RX_DATA || state_r == ST_RX_CRC) && rx_tick);
    assign crc_din = (state_r == ST_TX_DATA) ? exp_bit : rx_bit_q;

    frame_crc #(.WIDTH(16)) u_crc (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .clear(crc_clr),
        .shift(crc_shift),
        .din(crc_din),
        .crc(crc_val)
    );

    // ----------------------------------------------------------------
    // framing state machine
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_IDLE;
            idx_r <= 9'h000;
            plen_r <= 9'h000;
            cnt_r <= 4'h0;
            byte_r <= 8'h00;
            ram_addr <= 8'h00;
            ram_rd_en <= 1'b0;
            ram_wr_en <= 1'b0;
            ram_wdata <= 8'h00;
            tx_bit <= 1'b0;
            tx_bit_valid <= 1'b0;
            ev_r <= RST_IRQ;
        end
        else
        begin
            ram_rd_en <= 1'b0;
            ram_wr_en <= 1'b0;
            tx_bit_valid <= 1'b0;
            ev_r <= RST_IRQ;
            unique case (state_r)
                ST_IDLE:
                begin
                    idx_r <= 9'h000;
                    cnt_r <= 4'h0;
                    if (pkt_mode && tx_start)
                        state_r <= ST_TX_SYNC;
                    else if (pkt_mode && sync_det)
                        state_r <= ST_RX_DATA;
                end
                ST_TX_SYNC:
                    if (tx_bit_req)
                    begin
                        tx_bit <= sync_pattern[WORD_LAST - cnt_r];
                        tx_bit_valid <= 1'b1;
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == WORD_LAST)
                        begin
                            ram_addr <= tx_ptr_r;
                            ram_rd_en <= 1'b1;
                            state_r <= ST_TX_WAIT;
                        end
                    end
                ST_TX_WAIT:
                    state_r <= ST_TX_TAKE;
                ST_TX_TAKE:
                begin
                    byte_r <= ram_rdata;
                    cnt_r <= 4'h0;
                    state_r <= ST_TX_DATA;
                    if (idx_r == 9'h000)
                    begin
                        plen_r <= plen_calc;
                        if (len_bad)
                        begin
                            ev_r[IRQ_LEN_ERR] <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_TX_DATA:
                    if (tx_bit_req)
                    begin
                        tx_bit <= exp_bit;
                        tx_bit_valid <= 1'b1;
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r[2:0] == BYTE_LAST)
                        begin
                            cnt_r <= 4'h0;
                            idx_r <= idx_r + 9'h001;
                            if (idx_r + 9'h001 == plen_r)
                            begin
                                ev_r[IRQ_TX_DONE] <= !crc_en;
                                state_r <= crc_en ? ST_TX_CRC : ST_IDLE;
                            end
                            else
                            begin
                                ram_addr <= tx_ptr_r + idx_r[7:0] + 8'h01;
                                ram_rd_en <= 1'b1;
                                state_r <= ST_TX_WAIT;
                            end
                        end
                    end
                ST_TX_CRC:
                    if (tx_bit_req)
                    begin
                        tx_bit <= crc_val[WORD_LAST - cnt_r];
                        tx_bit_valid <= 1'b1;
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == WORD_LAST)
                        begin
                            ev_r[IRQ_TX_DONE] <= 1'b1;
                            state_r <= ST_IDLE;
                        end
                    end
                ST_RX_DATA:
                    if (rx_tick)
                    begin
                        byte_r <= rx_byte_nxt;
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r[2:0] == BYTE_LAST)
                        begin
                            cnt_r <= 4'h0;
                            idx_r <= idx_r + 9'h001;
                            if (idx_r == 9'h000)
                                plen_r <= plen_calc;
                            if (idx_r == 9'h000 && len_bad)
                            begin
                                ev_r[IRQ_LEN_ERR] <= 1'b1;
                                state_r <= ST_IDLE;
                            end
                            else
                            begin
                                ram_wr_en <= 1'b1;
                                ram_addr <= rx_ptr_r + idx_r[7:0];
                                ram_wdata <= rx_byte_nxt;
                                if (last_byte)
                                begin
                                    ev_r[IRQ_RX_DONE] <= !crc_en;
                                    state_r <= crc_en ? ST_RX_CRC : ST_IDLE;
                                end
                            end
                        end
                    end
                ST_RX_CRC:
                    if (rx_tick)
                    begin
                        cnt_r <= cnt_r + 4'h1;
                        if (cnt_r == WORD_LAST)
                            state_r <= ST_RX_CHECK;
                    end
                ST_RX_CHECK:
                begin
                    ev_r[IRQ_CRC_ERR] <= (crc_val != 16'h0000);
                    ev_r[IRQ_RX_DONE] <= 1'b1;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // streaming mode outputs
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            general_irq_output <= 1'b0;
            sport_rx_en <= 1'b0;
            sport_data <= 1'b0;
        end
        else
        begin
            general_irq_output <= (mode == MODE_SPORT_PRE && preamble_det) ||
                                  (mode == MODE_SPORT_SYNC && sync_det);
            if (mode != MODE_SPORT_PRE && mode != MODE_SPORT_SYNC)
                sport_rx_en <= 1'b0;
            else if (preamble_det)
                sport_rx_en <= 1'b1;
            sport_data <= sport_rx_en & rx_bit_q;
        end
    end

    // ----------------------------------------------------------------
    // apb slave and registers
    // ----------------------------------------------------------------
    assign setup = psel & ~penable;
    assign access_done = psel & penable & pready;
    assign reg_idx = paddr[11:2];
    assign known = idx_known(reg_idx) && (paddr[1:0] == 2'h0);
    assign ev_set = ev_r | {sync_det, preamble_det, 4'h0};
    assign w1c = (access_done && pwrite && !pslverr && reg_idx == IDX_IRQ_STAT) ?
                 pwdata[IRQ_W-1:0] : RST_IRQ;

    always_comb
    begin
        rd_val = 32'h0000_0000;
        unique case (reg_idx)
            IDX_SYNC_MID: rd_val = {24'h000000, sync_mid_r};
            IDX_SYNC_LOW: rd_val = {24'h000000, sync_low_r};
            IDX_TX_PTR: rd_val = {24'h000000, tx_ptr_r};
            IDX_RX_PTR: rd_val = {24'h000000, rx_ptr_r};
            IDX_FRAME: rd_val = {24'h000000, frame_r};
            IDX_LIMIT: rd_val = {24'h000000, limit_r};
            IDX_IRQ_STAT: rd_val = {26'h0000000, stat_r};
            IDX_IRQ_MASK: rd_val = {26'h0000000, mask_r};
            IDX_STATUS: rd_val = {20'h00000, state_r != ST_IDLE, mode, plen_r};
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup;
            pslverr <= setup && !known;
            prdata <= (setup && !pwrite && known) ? rd_val : 32'h0000_0000;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sync_mid_r <= RST_BYTE;
            sync_low_r <= RST_BYTE;
            tx_ptr_r <= RST_BYTE;
            rx_ptr_r <= RST_BYTE;
            frame_r <= RST_BYTE;
            limit_r <= RST_BYTE;
            mask_r <= RST_IRQ;
        end
        else if (access_done && pwrite && !pslverr)
        begin
            unique case (reg_idx)
                IDX_SYNC_MID: sync_mid_r <= pwdata[7:0];
                IDX_SYNC_LOW: sync_low_r <= pwdata[7:0];
                IDX_TX_PTR: tx_ptr_r <= pwdata[7:0];
                IDX_RX_PTR: rx_ptr_r <= pwdata[7:0];
                IDX_FRAME: frame_r <= pwdata[7:0];
                IDX_LIMIT: limit_r <= pwdata[7:0];
                IDX_IRQ_MASK: mask_r <= pwdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stat_r <= RST_IRQ;
            irq <= 1'b0;
        end
        else
        begin
            stat_r <= (stat_r & ~w1c) | ev_set;
            irq <= |(stat_r & mask_r);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    apb_ready_a: assert property (setup |=> pready ##1 !pready)
        else $error("apb answer not one cycle");
    sync_mid_a: assert property (
        access_done && pwrite && !pslverr && reg_idx == IDX_SYNC_MID
        |=> sync_pattern[15:8] == $past(pwdata[7:0]))
        else $error("middle sync byte not taken");
    sync_low_a: assert property (
        access_done && pwrite && !pslverr && reg_idx == IDX_SYNC_LOW
        |=> sync_pattern[7:0] == $past(pwdata[7:0]))
        else $error("low sync byte not taken");
    tx_first_a: assert property (
        $rose(state_r == ST_TX_WAIT) && idx_r == 9'h000 |-> ram_rd_en && ram_addr == tx_ptr_r)
        else $error("first tx byte from wrong address");
    rx_store_a: assert property (
        ram_wr_en |-> ram_addr == rx_ptr_r + idx_r[7:0] - 8'h01)
        else $error("rx byte stored at wrong address");
    bit_order_a: assert property (
        state_r == ST_TX_DATA && tx_bit_req |=> tx_bit_valid && tx_bit == $past(exp_bit))
        else $error("payload bit order wrong");
    crc_gate_a: assert property (
        (state_r == ST_TX_CRC || state_r == ST_RX_CHECK || ev_r[IRQ_CRC_ERR]) |-> crc_en)
        else $error("crc used while disabled");
    mode_pre_a: assert property (
        mode == MODE_SPORT_PRE && preamble_det |=> general_irq_output ##1 sport_rx_en)
        else $error("preamble irq missing");
    mode_sync_a: assert property (
        mode == MODE_SPORT_SYNC && sync_det |=> general_irq_output)
        else $error("sync irq missing");
    rx_stop_a: assert property (
        ram_wr_en |-> idx_r <= plen_r)
        else $error("stored past payload length");
    irq_out_a: assert property (|(stat_r & mask_r) |=> irq)
        else $error("interrupt not raised");
endmodule : packet_format_config

/* File: bench/packet_ram_model.sv */
// Purpose: packet ram seen from the packet handler
// Assumes: read data one cycle after the read strobe
// Notes: data goes stale (inverted) once the read slot ends
`timescale 1ns/1ns
module packet_ram_model (
    input wire logic core_clk,
    input wire logic [7:0] ram_addr,
    input wire logic ram_rd_en,
    input wire logic ram_wr_en,
    input wire logic [7:0] ram_wdata,
    output logic [7:0] ram_rdata
);
    logic [7:0] mem [0:255];
    logic rd_r = 1'b0;
    initial ram_rdata = 8'h00;
    always @(posedge core_clk)
    begin
        rd_r <= ram_rd_en;
        if (ram_rd_en) ram_rdata <= mem[ram_addr];
        else if (rd_r) ram_rdata <= ~ram_rdata;
        if (ram_wr_en) mem[ram_addr] <= ram_wdata;
    end
endmodule : packet_ram_model

/* File: bench/packet_format_config_bench.sv */
// Purpose: self-checking bench for the packet format configuration block
// Assumes: zero-wait apb slave, ram model on the far side
// Notes: serial rx pins driven bit by bit from the bench
`timescale 1ns/1ns
module packet_format_config_bench;
    import packet_format_pkg::*;
    logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, se, tx_start = 0, tx_bit_req = 0, tx_bit, tx_bit_valid;
    logic preamble_det = 0, sync_det = 0, ram_rd_en, ram_wr_en;
    logic rx_bit_pin = 0, rx_tick_pin = 0;
    logic [15:0] sync_pattern;
    logic [7:0] ram_addr, ram_rdata, ram_wdata;
    logic general_irq_output, sport_rx_en, sport_data, irq;
    logic [31:0] bits;
    int err_count = 0, samples_checked = 0;
    always #5 core_clk = ~core_clk;
    packet_format_config i_packet_format_config (.core_clk(core_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_start(tx_start),
        .tx_bit_req(tx_bit_req), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid),
        .rx_bit_pin(rx_bit_pin), .rx_tick_pin(rx_tick_pin), .preamble_det(preamble_det),
        .sync_det(sync_det), .sync_pattern(sync_pattern), .ram_addr(ram_addr),
        .ram_rd_en(ram_rd_en), .ram_rdata(ram_rdata), .ram_wr_en(ram_wr_en),
        .ram_wdata(ram_wdata), .general_irq_output(general_irq_output),
        .sport_rx_en(sport_rx_en), .sport_data(sport_data), .irq(irq));
    packet_ram_model i_packet_ram_model (.core_clk(core_clk), .ram_addr(ram_addr),
        .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en), .ram_wdata(ram_wdata),
        .ram_rdata(ram_rdata));
    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
        @(posedge core_clk);
        penable <= 1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task pulse_det(input logic pre);
        @(posedge core_clk);
        if (pre) preamble_det <= 1; else sync_det <= 1;
        @(posedge core_clk);
        preamble_det <= 0; sync_det <= 0;
        #1;
    endtask : pulse_det
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task test_regs;
        apb(0, IDX_FRAME, 8'h00); chk(rd, 32'h0);
        apb(1, IDX_SYNC_MID, 8'h3c); apb(1, IDX_SYNC_LOW, 8'h5a);
        apb(0, IDX_SYNC_MID, 8'h00); chk(rd, 32'h3c);
        apb(0, IDX_SYNC_LOW, 8'h00); chk(rd, 32'h5a);
        chk(sync_pattern, 16'h3c5a);
        apb(1, 10'h100, 8'h77); chk(se, 1'b1);
    endtask : test_regs
    task tx_frame(input int n);
        bits = 32'h0;
        @(posedge core_clk) tx_start <= 1;
        @(posedge core_clk) tx_start <= 0;
        for (int i = 0; i < n; i++)
        begin
            for (int t = 0; t < 6 && !tx_bit_valid; t++)
            begin
                @(posedge core_clk) tx_bit_req <= 1;
                @(posedge core_clk) tx_bit_req <= 0;
                @(posedge core_clk);
            end
            bits = {bits[30:0], tx_bit};
            @(posedge core_clk);
        end
    endtask : tx_frame
    task rx_send(input logic [7:0] v);
        for (int i = 7; i >= 0; i--)
        begin
            @(posedge core_clk) rx_bit_pin <= v[i];
            rx_tick_pin <= 0;
            repeat (6) @(posedge core_clk);
            rx_tick_pin <= 1;
            repeat (6) @(posedge core_clk);
        end
    endtask : rx_send
    task test_tx;
        i_packet_ram_model.mem[8'h40] = 8'ha5;
        apb(1, IDX_TX_PTR, 8'h40); apb(1, IDX_LIMIT, 8'h01);
        apb(1, IDX_FRAME, 8'hc4);
        tx_frame(24); chk(bits, 32'h3c5aa5);
        repeat (4) @(posedge core_clk);
        apb(0, IDX_IRQ_STAT, 8'h00); chk(rd[IRQ_TX_DONE], 1'b1);
    endtask : test_tx
    task test_tx_var;
        i_packet_ram_model.mem[8'h50] = 8'h03; i_packet_ram_model.mem[8'h51] = 8'h81;
        apb(1, IDX_IRQ_STAT, 8'h3f); apb(1, IDX_TX_PTR, 8'h50);
        apb(1, IDX_LIMIT, 8'h10); apb(1, IDX_FRAME, 8'h03);
        tx_frame(32); chk(bits, 32'h3c5ac081);
        repeat (4) @(posedge core_clk);
        apb(0, IDX_IRQ_STAT, 8'h00); chk(rd[IRQ_TX_DONE], 1'b1);
        i_packet_ram_model.mem[8'h50] = 8'h20;
        tx_frame(16); chk(bits, 32'h3c5a);
        repeat (4) @(posedge core_clk);
        apb(0, IDX_IRQ_STAT, 8'h00); chk(rd[IRQ_LEN_ERR], 1'b1);
    endtask : test_tx_var
    task test_rx;
        i_packet_ram_model.mem[8'h61] = 8'h00;
        apb(1, IDX_IRQ_STAT, 8'h3f); apb(1, IDX_RX_PTR, 8'h60);
        apb(1, IDX_LIMIT, 8'h01); apb(1, IDX_FRAME, 8'hc4);
        pulse_det(0); rx_send(8'h96); rx_send(8'h55);
        chk(i_packet_ram_model.mem[8'h60], 32'h96);
        chk(i_packet_ram_model.mem[8'h61], 32'h00);
        apb(0, IDX_IRQ_STAT, 8'h00); chk(rd[IRQ_RX_DONE], 1'b1);
    endtask : test_rx
    task test_sport;
        apb(1, IDX_IRQ_MASK, 8'h30); apb(1, IDX_IRQ_STAT, 8'h3f);
        apb(1, IDX_FRAME, 8'h08); pulse_det(1);
        chk(general_irq_output, 1'b1); chk(sport_rx_en, 1'b1);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b1);
        @(posedge core_clk) rx_bit_pin <= 1;
        repeat (8) @(posedge core_clk);
        chk(sport_data, 1'b1);
        apb(1, IDX_IRQ_STAT, 8'h30); repeat (2) @(posedge core_clk); chk(irq, 1'b0);
        apb(1, IDX_FRAME, 8'h10); pulse_det(1); chk(general_irq_output, 1'b0);
        pulse_det(0); chk(general_irq_output, 1'b1);
        apb(1, IDX_FRAME, 8'h00); repeat (2) @(posedge core_clk);
        chk(sport_rx_en, 1'b0);
    endtask : test_sport
    task finish_test;
        $display("errors %0d comparisons %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (16) @(posedge core_clk);
        rst_b <= 1;
        test_regs;
        test_tx;
        test_tx_var;
        test_rx;
        test_sport;
        finish_test;
    end
    initial
    begin
        #200000;
        err_count++;
        finish_test;
    end
endmodule : packet_format_config_bench
